// file: logic/src_reset_ctrl.sv
// Reset pulse control, reset cause, monitor identity, misc control, pulls and IO port.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] A one written to processor pulse bit n gives a 256-cycle reset pulse.
// [R2] Pulse outputs OR with level bits; pulse register reads return the combined lines.
// [R3] Pulse and monitor identity writes need key 0x5EC in bits 31:20.
// [R4] A one written to node pulse bit n gives a 256-cycle node reset pulse.
// [R5] A one written to subsystem pulse bit n gives a 256-cycle subsystem pulse.
// [R6] Subsystem bits: router, memory, networks, links, bus and clocks, whole chip.
// [R7] Reset cause reads a 3-bit code for power-on, watchdog, user, chip, interrupt.
// [R8] Writing subsystem pulse bit 17 requests a whole-chip reset.
// [R9] Power-on resets everything; monitor id becomes all ones, boot mapping clears.
// [R10] Watchdog, user and whole-chip resets keep the monitor identity field.
// [R11] User and whole-chip resets keep boot mapping; power-on and watchdog clear it.
// [R12] Watchdog interrupt pulses only the monitor processor, when enable bit 16 set.
// [R13] The monitor reset ignores processor masking; the interrupt reaches every processor.
// [R14] Monitor id takes the number of the first processor reading its arbitration register; a read by the old monitor is ignored.
// [R15] Writing one to bit 8 sets the arbitration flag; bit 8 reads it back.
// [R16] Misc register bits 20 to 16 read back pin samples.
// [R17] With bit 15 set, IO bits 27:24 drive the JTAG inputs.
// [R18] With external JTAG, those read bits return the real JTAG pin states.
// [R19] Misc bit 0 maps ROM or RAM into the boot area.
// [R20] Pull enables reset to all ones; bits 28:24 are unused.
// [R21] IO port is 32 bits, resets to zero, reads back its contents.
// [R22] Ethernet select high routes Ethernet nibbles onto IO pins 23:16.
// [R23] Level reset bits hold steady levels ORed with the pulse outputs, except subsystem bits 16 and 17.
// [R24] A winning arbitration read raises arb_won, loads the id and clears the flag.
// [R25] A write with a wrong key to a pulse or monitor identity register changes nothing and starts no pulse.
// [R26] A one written during an active pulse restarts its full count.
module src_reset_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr_unused_hi,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire src_pkg::src_cause_t reset_source,
  input wire logic watchdog_irq,
  input wire logic arb_read,
  input wire logic [4:0] arb_cpu,
  output logic arb_won,
  input wire logic [src_pkg::NUM_RST-1:0] cpu_level_bits,
  input wire logic [src_pkg::NUM_RST-1:0] node_level_bits,
  input wire logic [src_pkg::NUM_RST-1:0] subsys_level_bits,
  output src_pkg::src_resets_t reset_lines,
  output logic whole_chip_reset_req,
  output logic [src_pkg::NUM_RST-1:0] watchdog_irq_to_cpu,
  input wire src_pkg::src_straps_t straps,
  input wire src_pkg::src_jtag_pins_t jtag_pins,
  output src_pkg::src_jtag_drive_t jtag_drive,
  output logic jtag_drive_en,
  output logic boot_map_ram,
  output logic [31:0] pull_enable,
  input wire logic [31:0] io_pins_in,
  output logic [31:0] io_pins_out,
  input wire logic [3:0] eth_tx_nibble,
  output logic [3:0] eth_rx_nibble
);
  import src_pkg::*;

  // Key check shared by every protected register.
  function automatic logic key_ok(input logic [31:0] d);
    return d[31:KEY_LSB] == WRITE_KEY;
  endfunction : key_ok

  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic wr_key;
  logic wr_full;
  logic rd_fire;
  logic [31:0] rd_data;
  logic rd_known;
  logic wr_known;

  src_cause_t cause_r;
  logic [4:0] monitor_cpu_id_r;
  logic mon_rst_en_r;
  logic arb_flag_r;
  logic jtag_sw_r;
  logic boot_ram_r;
  logic [31:0] pull_en_r;
  logic [31:0] io_port_r;
  logic wd_irq_d_r;
  logic wd_rise;
  logic arb_win;
  logic rst_seen_r;

  logic [NUM_RST-1:0] cpu_fire;
  logic [NUM_RST-1:0] node_fire;
  logic [NUM_RST-1:0] subsys_fire;
  logic [NUM_RST-1:0] cpu_pulse;
  logic [NUM_RST-1:0] node_pulse;
  logic [NUM_RST-1:0] subsys_pulse;
  logic [31:0] io_view;

  // Address and data are latched independently so either may arrive first.
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_full = w_strb_r == 4'hF;
  assign wr_key = wr_full && key_ok(w_data_r); // [R3] [R25]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr_r)
      OFF_CPU_SOFT_PULSE, OFF_NODE_HARD_PULSE, OFF_SUBSYS_PULSE, OFF_RESET_CAUSE,
      OFF_MONITOR_ID, OFF_MISC_CTRL, OFF_PULL_EN, OFF_IO_PORT: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Pulse triggers: a keyed, full-word write with ones in the low bits fires, as does a watchdog rise for the monitor processor.
  always_comb begin
    cpu_fire = '0;
    node_fire = '0;
    subsys_fire = '0;
    if (wr_fire && wr_key) begin
      if (aw_addr_r == OFF_CPU_SOFT_PULSE) cpu_fire = w_data_r[NUM_RST-1:0]; // [R1] [R26]
      if (aw_addr_r == OFF_NODE_HARD_PULSE) node_fire = w_data_r[NUM_RST-1:0]; // [R4]
      if (aw_addr_r == OFF_SUBSYS_PULSE) subsys_fire = w_data_r[NUM_RST-1:0]; // [R5] [R6]
    end
    if (wd_rise && mon_rst_en_r && monitor_cpu_id_r < 5'(NUM_RST)) begin
      cpu_fire[monitor_cpu_id_r] = 1'b1; // [R12] [R13]
    end
  end

  src_pulse_gen u_cpu_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .fire(cpu_fire),
    .active(cpu_pulse)
  );

  src_pulse_gen u_node_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .fire(node_fire),
    .active(node_pulse)
  );

  src_pulse_gen u_subsys_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .fire(subsys_fire),
    .active(subsys_pulse)
  );

  assign reset_lines.cpu = cpu_pulse | cpu_level_bits; // [R2] [R23]
  assign reset_lines.node = node_pulse | node_level_bits; // [R2] [R23]
  // Bits 16 and 17 are pulse only, so their levels are not merged in.
  assign reset_lines.subsys = subsys_pulse | {2'b00, subsys_level_bits[15:0]}; // [R6] [R23]
  assign whole_chip_reset_req = subsys_pulse[SUBSYS_CHIP_BIT]; // [R8]

  // The watchdog interrupt line is fanned out unconditionally; masking is local.
  assign watchdog_irq_to_cpu = {NUM_RST{watchdog_irq}}; // [R13]
  assign wd_rise = watchdog_irq && !wd_irq_d_r;

  always_ff @(posedge clk) begin
    if (!rst_n) wd_irq_d_r <= 1'b0;
    else wd_irq_d_r <= watchdog_irq;
  end

  // The chip reset itself is this block's rst_n; reset_source says which kind it was.
  always_ff @(posedge clk) begin
    if (!rst_n) cause_r <= CAUSE_POWER_ON;
    else if (wd_rise) cause_r <= CAUSE_WATCHDOG_IRQ; // [R7]
    else if (reset_source != CAUSE_WATCHDOG_IRQ && reset_source != cause_r && rst_seen_r == 1'b0)
      cause_r <= reset_source; // [R7]
  end

  // Cause of the reset is captured once, on the first cycle after release.
  always_ff @(posedge clk) begin
    if (!rst_n) rst_seen_r <= 1'b0;
    else rst_seen_r <= 1'b1;
  end

  // Arbitration: a competitor wins only when the flag is set and it is not the old monitor.
  assign arb_win = arb_read && arb_flag_r && arb_cpu != monitor_cpu_id_r; // [R24]
  assign arb_won = arb_win;

  // Monitor id survives every reset but power-on, which the first cycle after release applies.
  always_ff @(posedge clk) begin
    if (rst_n && !rst_seen_r && reset_source == CAUSE_POWER_ON) begin
      monitor_cpu_id_r <= MON_ID_POR; // [R9] [R10]
    end else if (rst_n && arb_win) begin
      monitor_cpu_id_r <= arb_cpu; // [R14] [R24]
    end else if (rst_n && wr_fire && wr_key && aw_addr_r == OFF_MONITOR_ID) begin
      monitor_cpu_id_r <= w_data_r[4:0];
    end
  end

  // The arbitration flag is set by every hard reset; a win beats a software set.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arb_flag_r <= 1'b1;
      mon_rst_en_r <= 1'b0;
    end else begin
      if (arb_win) arb_flag_r <= 1'b0; // [R24]
      else if (wr_fire && wr_key && aw_addr_r == OFF_MONITOR_ID && w_data_r[MON_ARB_BIT])
        arb_flag_r <= 1'b1; // [R15]
      if (wr_fire && wr_key && aw_addr_r == OFF_MONITOR_ID)
        mon_rst_en_r <= w_data_r[MON_RST_EN_BIT]; // [R12]
    end
  end

  // Boot mapping survives user and whole-chip resets only.
  always_ff @(posedge clk) begin
    if (rst_n && !rst_seen_r &&
        (reset_source == CAUSE_POWER_ON || reset_source == CAUSE_WATCHDOG_RESET)) begin
      boot_ram_r <= 1'b0; // [R9] [R11]
    end else if (rst_n && wr_fire && wr_full && aw_addr_r == OFF_MISC_CTRL) begin
      boot_ram_r <= w_data_r[MISC_BOOT_RAM_BIT]; // [R19]
    end
  end
  assign boot_map_ram = boot_ram_r; // [R19]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      jtag_sw_r <= 1'b0;
      pull_en_r <= PULL_EN_RESET; // [R20]
      io_port_r <= IO_PORT_RESET; // [R21]
    end else if (wr_fire && wr_full) begin
      if (aw_addr_r == OFF_MISC_CTRL) jtag_sw_r <= w_data_r[MISC_JTAG_SW_BIT]; // [R17]
      if (aw_addr_r == OFF_PULL_EN) pull_en_r <= w_data_r; // [R20]
      if (aw_addr_r == OFF_IO_PORT) io_port_r <= w_data_r; // [R21]
    end
  end
  assign pull_enable = pull_en_r & PULL_EN_MASK; // [R20]

  // Software JTAG drive comes from IO port bits 27:24.
  assign jtag_drive = src_jtag_drive_t'(io_port_r[JTAG_IO_LSB +: 4]); // [R17]
  assign jtag_drive_en = jtag_sw_r; // [R17]

  // Ethernet select steals the pins of IO bits 23:16 for the MII nibbles.
  always_comb begin
    io_pins_out = io_port_r;
    if (straps.eth_select) io_pins_out[ETH_IO_LSB +: 8] = {eth_tx_nibble, 4'h0}; // [R22]
  end
  assign eth_rx_nibble = straps.eth_select ? io_pins_in[ETH_IO_LSB +: 4] : 4'h0; // [R22]

  // Under external JTAG the port view shows the real pin states.
  always_comb begin
    io_view = io_port_r; // [R21]
    if (!jtag_sw_r) begin
      io_view[JTAG_IO_LSB +: 4] = {jtag_pins.trst, jtag_pins.tms, jtag_pins.tdi,
                                   jtag_pins.tck}; // [R18]
    end
  end

  always_comb begin
    rd_known = 1'b1;
    rd_data = 32'h00000000;
    unique case (s_axi_araddr)
      OFF_CPU_SOFT_PULSE: rd_data[NUM_RST-1:0] = reset_lines.cpu; // [R2]
      OFF_NODE_HARD_PULSE: rd_data[NUM_RST-1:0] = reset_lines.node; // [R2]
      OFF_SUBSYS_PULSE: rd_data[NUM_RST-1:0] = reset_lines.subsys; // [R2]
      OFF_RESET_CAUSE: rd_data[2:0] = cause_r; // [R7]
      OFF_MONITOR_ID: begin
        rd_data[4:0] = monitor_cpu_id_r;
        rd_data[MON_ARB_BIT] = arb_flag_r; // [R15]
        rd_data[MON_RST_EN_BIT] = mon_rst_en_r;
      end
      OFF_MISC_CTRL: begin
        rd_data[MISC_RTCK_BIT] = jtag_pins.rtck; // [R16] [R17]
        rd_data[MISC_TDO_BIT] = jtag_pins.tdo; // [R16] [R18]
        rd_data[MISC_SLOW_CLK_BIT] = straps.slow_clock_pin; // [R16]
        rd_data[MISC_ETH_SEL_BIT] = straps.eth_select; // [R16]
        rd_data[MISC_TEST_BIT] = straps.test_pin; // [R16]
        rd_data[MISC_JTAG_SW_BIT] = jtag_sw_r;
        rd_data[MISC_BOOT_RAM_BIT] = boot_ram_r;
      end
      OFF_PULL_EN: rd_data = pull_enable;
      OFF_IO_PORT: rd_data = io_view;
      default: rd_known = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unused_hi;
  assign unused_hi = ^s_axi_awaddr_unused_hi;

endmodule : src_reset_ctrl
`default_nettype wire

// file: logic/src_pkg.sv
// Package of register map, field positions, reset values and types for the reset controller.
package src_pkg;

  localparam logic [7:0] OFF_CPU_SOFT_PULSE = 8'h24;
  localparam logic [7:0] OFF_NODE_HARD_PULSE = 8'h28;
  localparam logic [7:0] OFF_SUBSYS_PULSE = 8'h2C;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'h30;
  localparam logic [7:0] OFF_MONITOR_ID = 8'h34;
  localparam logic [7:0] OFF_MISC_CTRL = 8'h38;
  localparam logic [7:0] OFF_PULL_EN = 8'h3C;
  localparam logic [7:0] OFF_IO_PORT = 8'h40;

  localparam int NUM_RST = 18;
  localparam logic [11:0] WRITE_KEY = 12'h5EC;
  localparam int KEY_LSB = 20;
  localparam int PULSE_CYCLES = 256;
  localparam int PULSE_CNT_W = 8;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = 8'(PULSE_CYCLES - 1);

  localparam int SUBSYS_CHIP_BIT = 17;
  localparam int MON_RST_EN_BIT = 16;
  localparam int MON_ARB_BIT = 8;
  localparam logic [4:0] MON_ID_POR = 5'h1F;

  localparam int MISC_RTCK_BIT = 20;
  localparam int MISC_TDO_BIT = 19;
  localparam int MISC_SLOW_CLK_BIT = 18;
  localparam int MISC_ETH_SEL_BIT = 17;
  localparam int MISC_TEST_BIT = 16;
  localparam int MISC_JTAG_SW_BIT = 15;
  localparam int MISC_BOOT_RAM_BIT = 0;

  localparam logic [31:0] PULL_EN_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] PULL_EN_MASK = 32'hE0FFFFFF;
  localparam logic [31:0] IO_PORT_RESET = 32'h00000000;
  localparam logic [31:0] ARB_WIN_DATA = 32'h80000000;
  localparam int JTAG_IO_LSB = 24;
  localparam int ETH_IO_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'h0,
    CAUSE_WATCHDOG_RESET = 3'h1,
    CAUSE_USER_RESET = 3'h2,
    CAUSE_WHOLE_CHIP = 3'h3,
    CAUSE_WATCHDOG_IRQ = 3'h4
  } src_cause_t;

  typedef struct packed {
    logic trst;
    logic tms;
    logic tdi;
    logic tck;
  } src_jtag_drive_t;

  typedef struct packed {
    logic rtck;
    logic tdo;
    logic trst;
    logic tms;
    logic tdi;
    logic tck;
  } src_jtag_pins_t;

  typedef struct packed {
    logic slow_clock_pin;
    logic eth_select;
    logic test_pin;
  } src_straps_t;

  typedef struct packed {
    logic [NUM_RST-1:0] cpu;
    logic [NUM_RST-1:0] node;
    logic [NUM_RST-1:0] subsys;
  } src_resets_t;

endpackage : src_pkg

// file: logic/src_pulse_gen.sv
// Bank of retriggerable fixed-length reset pulse generators.
`timescale 1ns/1ps
`default_nettype none
module src_pulse_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [src_pkg::NUM_RST-1:0] fire,
  output logic [src_pkg::NUM_RST-1:0] active
);
  import src_pkg::*;

  logic [PULSE_CNT_W-1:0] cnt_r [NUM_RST];

  // A fire while already active reloads the count, so the pulse restarts in full.
  for (genvar i = 0; i < NUM_RST; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        active[i] <= 1'b0;
        cnt_r[i] <= '0;
      end else if (fire[i]) begin
        active[i] <= 1'b1;
        cnt_r[i] <= '0;
      end else if (active[i]) begin
        if (cnt_r[i] == PULSE_LAST) begin
          active[i] <= 1'b0;
        end
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end
  end

endmodule : src_pulse_gen
`default_nettype wire

// file: verif/src_reset_ctrl_sva.sv
// Port-level assertion checker for the reset controller.
`timescale 1ns/1ps
`default_nettype none
module src_reset_ctrl_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic watchdog_irq,
  input wire logic [src_pkg::NUM_RST-1:0] watchdog_irq_to_cpu,
  input wire logic arb_read,
  input wire logic arb_won,
  input wire logic [src_pkg::NUM_RST-1:0] cpu_level_bits,
  input wire logic [src_pkg::NUM_RST-1:0] node_level_bits,
  input wire logic [src_pkg::NUM_RST-1:0] subsys_level_bits,
  input wire src_pkg::src_resets_t reset_lines,
  input wire logic whole_chip_reset_req,
  input wire src_pkg::src_straps_t straps,
  input wire logic [31:0] io_pins_in,
  input wire logic [31:0] io_pins_out,
  input wire logic [3:0] eth_tx_nibble,
  input wire logic [3:0] eth_rx_nibble,
  input wire logic [31:0] pull_enable
);
  import src_pkg::*;
  // Saturating count of high cycles, so a stuck request cannot wrap and pass.
  logic [8:0] chip_cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n || !whole_chip_reset_req) begin
      chip_cnt_r <= 9'h000;
    end else if (chip_cnt_r != 9'h1FF) begin
      chip_cnt_r <= chip_cnt_r + 9'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_LEVEL_CPU: assert property ((reset_lines.cpu & cpu_level_bits) == cpu_level_bits)
    else $error("cpu level bit missing on reset line");
  AST_LEVEL_NODE: assert property (
    (reset_lines.node & node_level_bits) == node_level_bits)
    else $error("node level bit missing on reset line");
  AST_LEVEL_SUBSYS: assert property (
    (reset_lines.subsys[15:0] & subsys_level_bits[15:0]) == subsys_level_bits[15:0])
    else $error("subsystem level bit missing on reset line");
  AST_CHIP_REQ: assert property (whole_chip_reset_req == reset_lines.subsys[17])
    else $error("chip request differs from subsystem line 17");
  AST_CHIP_LEN: assert property ($fell(whole_chip_reset_req) |-> chip_cnt_r >= 9'h100)
    else $error("subsystem pulse shorter than 256 cycles");
  AST_WD_FANOUT: assert property (watchdog_irq_to_cpu == {NUM_RST{watchdog_irq}})
    else $error("watchdog interrupt not at every processor");
  AST_ARB_ONCE: assert property (arb_won |-> arb_read ##1 !arb_won)
    else $error("arbitration won twice in a row");
  AST_ETH_TX: assert property (
    straps.eth_select |-> io_pins_out[23:16] == {eth_tx_nibble, 4'h0})
    else $error("transmit nibble not on io pins");
  AST_ETH_RX: assert property (
    eth_rx_nibble == (straps.eth_select ? io_pins_in[19:16] : 4'h0))
    else $error("receive nibble wrong");
  AST_PULL_UNUSED: assert property (pull_enable[28:24] == 5'h00)
    else $error("unused pull enables driven");
endmodule : src_reset_ctrl_sva
bind src_reset_ctrl src_reset_ctrl_sva u_sva (.clk, .rst_n, .watchdog_irq,
  .watchdog_irq_to_cpu, .arb_read, .arb_won, .cpu_level_bits, .node_level_bits,
  .subsys_level_bits, .reset_lines, .whole_chip_reset_req, .straps, .io_pins_in,
  .io_pins_out, .eth_tx_nibble, .eth_rx_nibble, .pull_enable);
`default_nettype wire

// file: verif/src_reset_ctrl_tb.sv
// Self-checking bench for the reset controller over its register bus and side ports.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module src_reset_ctrl_tb;
  import src_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, pull_enable, io_pins_out;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Responses are always accepted at once, so the bus never stalls the checks.
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, watchdog_irq = 1'b0, arb_read = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, arb_won;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] io_pins_in = 32'h00050000;
  src_cause_t reset_source = CAUSE_POWER_ON;
  logic [4:0] arb_cpu = 5'h00;
  logic [NUM_RST-1:0] cpu_level_bits = 18'h00000, node_level_bits = 18'h00000;
  logic [NUM_RST-1:0] subsys_level_bits = 18'h00000, watchdog_irq_to_cpu;
  src_resets_t reset_lines;
  logic whole_chip_reset_req, jtag_drive_en, boot_map_ram;
  src_straps_t straps = 3'h5;
  src_jtag_pins_t jtag_pins = 6'h20;
  src_jtag_drive_t jtag_drive;
  logic [3:0] eth_tx_nibble = 4'h9, eth_rx_nibble;
  int errors = 0, cmp_count = 0, cyc = 0, hi_cnt = 0, t0, t1;
  src_cause_t src_tab [4] = '{CAUSE_USER_RESET, CAUSE_WHOLE_CHIP, CAUSE_WATCHDOG_RESET,
    CAUSE_POWER_ON};
  logic [31:0] id_tab [4] = '{32'h00000107, 32'h00000107, 32'h00000107, 32'h0000011F};
  logic boot_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  src_reset_ctrl dut (.clk, .rst_n, .s_axi_awaddr_unused_hi(4'h0), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_source, .watchdog_irq, .arb_read, .arb_cpu, .arb_won,
    .cpu_level_bits, .node_level_bits, .subsys_level_bits, .reset_lines,
    .whole_chip_reset_req, .watchdog_irq_to_cpu, .straps, .jtag_pins, .jtag_drive,
    .jtag_drive_en, .boot_map_ram, .pull_enable, .io_pins_in, .io_pins_out,
    .eth_tx_nibble, .eth_rx_nibble);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reset_lines.cpu[3]) hi_cnt <= hi_cnt + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK("bresp", s_axi_bresp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    if (er === RESP_OKAY) `CHK("rdata", s_axi_rdata, e)
    `CHK("rresp", s_axi_rresp, er)
  endtask : rd
  // Waits for processor 3's reset line to rise and fall, then checks its length.
  task automatic measure(input int exp_len);
    for (int i = 0; i < 10 && !reset_lines.cpu[3]; i++) @(posedge clk);
    for (int i = 0; i < 600 && reset_lines.cpu[3]; i++) @(posedge clk);
    `CHK("pulse length", hi_cnt, exp_len)
    hi_cnt = 0;
  endtask : measure
  task automatic arb(input logic [4:0] n, input logic exp);
    arb_cpu <= n;
    arb_read <= 1'b1;
    @(negedge clk);
    `CHK("arb_won", arb_won, exp)
    @(posedge clk);
    arb_read <= 1'b0;
  endtask : arb
  task automatic do_reset(input src_cause_t src);
    rst_n <= 1'b0;
    reset_source <= src;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  initial begin
    do_reset(CAUSE_POWER_ON);
    rd(OFF_MONITOR_ID, 32'h0000011F, RESP_OKAY);
    wr(OFF_RESET_CAUSE, 32'h5EC00007, RESP_OKAY);
    rd(OFF_RESET_CAUSE, 32'h00000000, RESP_OKAY);
    rd(OFF_IO_PORT, IO_PORT_RESET, RESP_OKAY);
    rd(OFF_MISC_CTRL, 32'h00150000, RESP_OKAY);
    `CHK("pull_enable", pull_enable, 32'hE0FFFFFF)
    wr(8'h44, 32'h5EC00001, RESP_SLVERR);
    rd(8'h20, 32'h00000000, RESP_SLVERR);
    wr(OFF_CPU_SOFT_PULSE, 32'h12300008, RESP_OKAY);
    wr(OFF_MONITOR_ID, 32'h00010003, RESP_OKAY);
    rd(OFF_CPU_SOFT_PULSE, 32'h00000000, RESP_OKAY);
    rd(OFF_MONITOR_ID, 32'h0000011F, RESP_OKAY);
    s_axi_wstrb <= 4'h3;
    wr(OFF_IO_PORT, 32'hFFFFFFFF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFF_IO_PORT, 32'h00000000, RESP_OKAY);
    cpu_level_bits <= 18'h00020;
    node_level_bits <= 18'h00004;
    subsys_level_bits <= 18'h30001;
    rd(OFF_CPU_SOFT_PULSE, 32'h00000020, RESP_OKAY);
    rd(OFF_SUBSYS_PULSE, 32'h00000001, RESP_OKAY);
    wr(OFF_CPU_SOFT_PULSE, 32'h5EC00008, RESP_OKAY);
    rd(OFF_CPU_SOFT_PULSE, 32'h00000028, RESP_OKAY);
    measure(PULSE_CYCLES);
    t0 = cyc;
    wr(OFF_CPU_SOFT_PULSE, 32'h5EC00008, RESP_OKAY);
    repeat (100) @(posedge clk);
    t1 = cyc;
    wr(OFF_CPU_SOFT_PULSE, 32'h5EC00008, RESP_OKAY);
    measure(PULSE_CYCLES + t1 - t0);
    wr(OFF_NODE_HARD_PULSE, 32'h5EC00001, RESP_OKAY);
    rd(OFF_NODE_HARD_PULSE, 32'h00000005, RESP_OKAY);
    wr(OFF_SUBSYS_PULSE, 32'h5EC3FFFF, RESP_OKAY);
    `CHK("chip request", whole_chip_reset_req, 1'b1)
    rd(OFF_SUBSYS_PULSE, 32'h0003FFFF, RESP_OKAY);
    repeat (PULSE_CYCLES) @(posedge clk);
    `CHK("subsys lines", reset_lines.subsys, 18'h00001)
    `CHK("node lines", reset_lines.node, 18'h00004)
    wr(OFF_MONITOR_ID, 32'h5EC00003, RESP_OKAY);
    watchdog_irq <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK("masked pulse", hi_cnt, 0)
    watchdog_irq <= 1'b0;
    wr(OFF_MONITOR_ID, 32'h5EC10003, RESP_OKAY);
    rd(OFF_MONITOR_ID, 32'h00010103, RESP_OKAY);
    watchdog_irq <= 1'b1;
    measure(PULSE_CYCLES);
    `CHK("irq fanout", watchdog_irq_to_cpu, 18'h3FFFF)
    rd(OFF_RESET_CAUSE, 32'h00000004, RESP_OKAY);
    watchdog_irq <= 1'b0;
    arb(5'h07, 1'b1);
    rd(OFF_MONITOR_ID, 32'h00010007, RESP_OKAY);
    arb(5'h09, 1'b0);
    wr(OFF_MONITOR_ID, 32'h5EC10107, RESP_OKAY);
    rd(OFF_MONITOR_ID, 32'h00010107, RESP_OKAY);
    wr(OFF_MISC_CTRL, 32'h00008001, RESP_OKAY);
    wr(OFF_IO_PORT, 32'h0AFF0000, RESP_OKAY);
    `CHK("jtag_drive", jtag_drive, 4'hA)
    `CHK("jtag_drive_en", jtag_drive_en, 1'b1)
    `CHK("boot_map_ram", boot_map_ram, 1'b1)
    `CHK("io out", io_pins_out, 32'h0AFF0000)
    straps <= 3'h7;
    jtag_pins <= 6'h10;
    rd(OFF_MISC_CTRL, 32'h000F8001, RESP_OKAY);
    `CHK("io out", io_pins_out, 32'h0A900000)
    `CHK("rx nibble", eth_rx_nibble, 4'h5)
    wr(OFF_MISC_CTRL, 32'h00000001, RESP_OKAY);
    `CHK("jtag_drive_en", jtag_drive_en, 1'b0)
    jtag_pins <= 6'h15;
    rd(OFF_IO_PORT, 32'h05FF0000, RESP_OKAY);
    rd(OFF_MISC_CTRL, 32'h000F0001, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      do_reset(src_tab[k]);
      rd(OFF_RESET_CAUSE, {29'h00000000, src_tab[k]}, RESP_OKAY);
      rd(OFF_MONITOR_ID, id_tab[k], RESP_OKAY);
      `CHK("boot_map_ram", boot_map_ram, boot_tab[k])
    end
    give_verdict();
  end
endmodule : src_reset_ctrl_tb
`default_nettype wire
